//--- core/hdic_pkg.sv
// Shared constants, types and helpers of the host DMA and interrupt pin
// configuration block. Both ends of the link use it.
// Assumes one 16-bit microprocessor command link between the two ends.
package hdic_pkg;

  // Link widths.
  localparam int DATA_W = 16;
  localparam int CODE_W = 8;

  // Command codes; a write code is the read code with bit 7 set.
  localparam logic [7:0] CMD_HW = 8'h20;
  localparam logic [7:0] CMD_DMA = 8'h21;
  localparam logic [7:0] CMD_CNT = 8'h22;
  localparam logic [7:0] CMD_EVT = 8'h24;
  localparam logic [7:0] CMD_MASK = 8'h25;
  localparam int CMD_WR_BIT = 7;

  // Pin setup field positions.
  localparam int HW_OC_SEL = 10;
  localparam int HW_ONE_IRQ = 9;
  localparam int HW_ACK_MODE = 8;
  localparam int HW_ONE_XFER = 7;
  localparam int HW_ACK_POL = 6;
  localparam int HW_REQ_POL = 5;
  localparam int HW_WIDTH_LO = 3;
  localparam int HW_IRQ_POL = 2;
  localparam int HW_IRQ_TRIG = 1;
  localparam int HW_IRQ_EN = 0;
  localparam logic [15:0] HW_RESET = 16'h0028;
  localparam logic [1:0] BUS_W16 = 2'b01;

  // Transfer setup field positions.
  localparam int DMA_CNT_EN = 7;
  localparam int DMA_BURST_LO = 5;
  localparam int DMA_XFER_EN = 4;
  localparam int DMA_BUF_LO = 1;
  localparam int DMA_DIR = 0;
  localparam logic [15:0] DMA_RESET = 16'h0000;
  localparam logic [15:0] DMA_USED = 16'h00FF;
  localparam logic [1:0] BURST_RSVD = 2'b11;

  // Byte counter and event flags.
  localparam logic [15:0] CNT_RESET = 16'h0000;
  localparam logic [15:0] BYTES_PER_ACK = 16'h0002;
  localparam int EVT_ALL_DONE = 2;
  localparam int EVT_W = 10;
  localparam logic [15:0] EVT_USED = 16'h03FF;
  localparam logic [15:0] EVT_RESET = 16'h0000;
  localparam logic [15:0] MASK_RESET = 16'h0000;

  // Controller register offsets on the software port.
  localparam int HADDR_W = 5;
  localparam logic [4:0] H_DATA = 5'h00;
  localparam logic [4:0] H_CMD = 5'h04;
  localparam logic [4:0] H_RX = 5'h08;
  localparam logic [4:0] H_STAT = 5'h0C;
  localparam logic [4:0] H_CTRL = 5'h10;
  // Controller control and status bits.
  localparam int CTRL_ACK_EN = 0;
  localparam int CTRL_ACK_POL = 1;
  localparam int CTRL_REQ_POL = 2;
  localparam int CTRL_IRQ_POL = 3;
  localparam logic [3:0] CTRL_RESET = 4'h4;
  localparam int ST_RX_NEW = 0;
  localparam int ST_IRQ1 = 1;
  localparam int ST_IRQ2 = 2;
  localparam int ST_REQ1 = 3;

  // Transfer sequencing states.
  typedef enum logic [1:0] {DMA_IDLE, DMA_ACTIVE, DMA_DONE} hdic_dma_st_t;

  // Whole state of the device end.
  typedef struct packed {
    logic [15:0] hw;
    logic [15:0] dma;
    logic [15:0] cnt;
    logic [15:0] evt;
    logic [15:0] mask;
    hdic_dma_st_t st;
    logic raw_d;
    logic rsp_valid;
    logic [15:0] rsp_data;
    logic irq_one;
    logic irq_two;
    logic req_one;
    logic req_two;
    logic periph_ack;
    logic end_of_transfer;
    logic buf_upd;
    logic word;
    logic oc;
  } hdic_dev_t;

  localparam hdic_dev_t DEV_RESET = '{hw: HW_RESET, dma: DMA_RESET,
    cnt: CNT_RESET, evt: EVT_RESET, mask: MASK_RESET, st: DMA_IDLE,
    irq_one: 1'b1, irq_two: 1'b1, default: '0};

  // Whole state of the controller end.
  typedef struct packed {
    logic [15:0] data;
    logic [3:0] ctrl;
    logic cmd_valid;
    logic [7:0] cmd_code;
    logic [15:0] cmd_wdata;
    logic [15:0] rx;
    logic rx_new;
    logic ack1_act;
    logic ack_one;
    logic ack_two;
    logic [15:0] rd_data;
  } hdic_host_t;

  localparam hdic_host_t HOST_RESET = '{ctrl: CTRL_RESET, ack_one: 1'b1,
    default: '0};

  // Maps an active level to a pin level and back: low when pol is 0.
  function automatic logic pol_apply(input logic x, input logic pol);
    pol_apply = pol ? x : ~x;
  endfunction : pol_apply

endpackage : hdic_pkg

//--- core/hdic_bus_if.sv
// Link between the controller end and the device end: command port plus
// interrupt, request and acknowledge pins.
// Assumes both ends run on the same clock.
`timescale 1ns/100ps
interface hdic_bus_if;
  logic cmd_valid; // One-cycle command strobe.
  logic [hdic_pkg::CODE_W-1:0] cmd_code; // Command code.
  logic [hdic_pkg::DATA_W-1:0] cmd_wdata; // Write data.
  logic rsp_valid; // Read answer strobe.
  logic [hdic_pkg::DATA_W-1:0] rsp_data; // Read answer data.
  logic irq_one; // Interrupt pin one.
  logic irq_two; // Interrupt pin two.
  logic req_one; // Request pin one.
  logic req_two; // Request pin two, active high.
  logic ack_one; // Acknowledge pin one.
  logic ack_two; // Acknowledge pin two, active high.

  modport dev (
    input cmd_valid, cmd_code, cmd_wdata, ack_one, ack_two,
    output rsp_valid, rsp_data, irq_one, irq_two, req_one, req_two
  );
  modport host (
    output cmd_valid, cmd_code, cmd_wdata, ack_one, ack_two,
    input rsp_valid, rsp_data, irq_one, irq_two, req_one, req_two
  );
endinterface : hdic_bus_if

//--- core/hdic_device.sv
// Device end: pin setup, transfer setup, byte counter and event flags,
// with interrupt and request pin shaping.
// Assumes the controller sends one command per strobe and keeps the
// acknowledge pins synchronous to sys_clk_i.
`timescale 1ns/100ps
// How it works
// - Overcurrent source: 0 digital, 1 analog.
// - Interrupts split over two pins or merged.
// - Acknowledge mode 0 qualifies ack one.
// - Requests split over two pairs or merged.
// - Ack one polarity: 0 low, 1 high.
// - Request one polarity, resets active high.
// - Bus width field held at 16-bit code.
// - Interrupt one polarity, resets active low.
// - Interrupt one level or edge pulse.
// - Host interrupt needs global enable and mask.
// - Counter enable and non-zero count arm request.
// - Burst code 11 is never stored.
// - Software clears transfer enable after completion.
// - Direction 0 reads from buffer memory.
// - Counter governs length; buffer area select.
// - Count acts only with counter enable set.
// - Count reached: end pulse, flag, buffer update.
// - Byte count is 16-bit, resets zero.
// - Transfer setup codes 21 read, A1 write.
// - Byte count codes 22 read, A2 write.
module hdic_device (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Link to the controller.
  hdic_bus_if.dev bus,
  // Event sources of the host core, one-cycle pulses.
  input wire logic [hdic_pkg::EVT_W-1:0] host_evt_i,
  // Peripheral side interrupt and request levels.
  input wire logic periph_irq_i,
  input wire logic periph_req_i,
  output logic periph_ack_o,
  // Overcurrent inputs and the selected result.
  input wire logic oc_digital_i,
  input wire logic oc_analog_i,
  output logic overcurrent_o,
  // Transfer progress towards the buffer memory.
  output logic eot_o,
  output logic buf_state_upd_o,
  output logic word_done_o,
  output logic xfer_dir_o,
  output logic [1:0] burst_len_o,
  output logic [2:0] buf_sel_o
);

  // Registered state and its next value.
  hdic_pkg::hdic_dev_t state_reg;
  hdic_pkg::hdic_dev_t state_next;

  // Decoded command strobes.
  logic is_wr; // A write command arrived.
  logic is_rd; // A read command arrived.
  logic [6:0] base; // Code without the write flag.
  // Pin side helpers.
  logic ack1_act; // Ack one after polarity and mode.
  logic host_ack; // Ack one spent on the host transfer.
  logic raw_irq; // Host interrupt before trigger shaping.
  logic host_irq; // Host interrupt after trigger shaping.
  logic one_act; // Active level for interrupt pin one.
  logic two_act; // Active level for interrupt pin two.
  logic req1_act; // Active level for request pin one.
  logic done_now; // Byte count just reached.
  logic [15:0] cnt_dec; // Count after one acknowledged word.
  logic [15:0] wclr; // Event bits cleared by software.
  logic [15:0] wd; // Incoming write data.

  // All logic of the block; each field of the next state is decided here.
  always_comb begin
    state_next = state_reg;
    state_next.rsp_valid = 1'b0;
    state_next.rsp_data = '0;
    state_next.end_of_transfer = 1'b0;
    state_next.buf_upd = 1'b0;
    state_next.word = 1'b0;
    state_next.periph_ack = 1'b0;
    wd = bus.cmd_wdata;
    wclr = '0;
    done_now = 1'b0;
    cnt_dec = state_reg.cnt;
    base = bus.cmd_code[6:0];
    is_wr = bus.cmd_valid && bus.cmd_code[hdic_pkg::CMD_WR_BIT];
    is_rd = bus.cmd_valid && !bus.cmd_code[hdic_pkg::CMD_WR_BIT];

    // Ack one counts only in normal mode; the reserved mode ignores it.
    ack1_act = hdic_pkg::pol_apply(bus.ack_one,
      state_reg.hw[hdic_pkg::HW_ACK_POL])
      && !state_reg.hw[hdic_pkg::HW_ACK_MODE];
    host_ack = ack1_act && (state_reg.st == hdic_pkg::DMA_ACTIVE);

    // Peripheral acknowledge comes from pair one only when merged.
    if (state_reg.hw[hdic_pkg::HW_ONE_XFER]) begin
      state_next.periph_ack = ack1_act && !host_ack && periph_req_i;
    end else begin
      state_next.periph_ack = bus.ack_two && periph_req_i;
    end

    // Each acknowledged word moves two bytes; an odd last byte ends it.
    if (host_ack) begin
      if (state_reg.cnt > hdic_pkg::BYTES_PER_ACK) begin
        cnt_dec = state_reg.cnt - hdic_pkg::BYTES_PER_ACK;
      end else begin
        cnt_dec = '0;
        done_now = 1'b1;
      end
      state_next.cnt = cnt_dec;
      state_next.word = 1'b1;
    end

    // Reaching the count ends the transfer and updates buffer state.
    if (done_now) begin
      state_next.end_of_transfer = 1'b1;
      state_next.buf_upd = 1'b1;
    end

    // Software writes; a count write beats a same-cycle decrement.
    if (is_wr) begin
      if (base == hdic_pkg::CMD_HW[6:0]) begin
        state_next.hw = wd;
        // Only the 16-bit width code is legal, so it cannot be left.
        state_next.hw[hdic_pkg::HW_WIDTH_LO +: 2] = hdic_pkg::BUS_W16;
      end else if (base == hdic_pkg::CMD_DMA[6:0]) begin
        state_next.dma = wd & hdic_pkg::DMA_USED;
        // A reserved burst code keeps the previous burst length.
        if (wd[hdic_pkg::DMA_BURST_LO +: 2] == hdic_pkg::BURST_RSVD) begin
          state_next.dma[hdic_pkg::DMA_BURST_LO +: 2] =
            state_reg.dma[hdic_pkg::DMA_BURST_LO +: 2];
        end
      end else if (base == hdic_pkg::CMD_CNT[6:0]) begin
        state_next.cnt = wd;
      end else if (base == hdic_pkg::CMD_EVT[6:0]) begin
        wclr = wd;
      end else if (base == hdic_pkg::CMD_MASK[6:0]) begin
        state_next.mask = wd & hdic_pkg::EVT_USED;
      end
    end

    // Software clears first, hardware sets after, so no event is lost.
    state_next.evt = (state_reg.evt & ~wclr) |
      ({6'h00, host_evt_i} & hdic_pkg::EVT_USED);
    if (done_now) begin
      state_next.evt[hdic_pkg::EVT_ALL_DONE] = 1'b1;
    end

    // Reads answer in the next cycle; unknown codes answer zero.
    if (is_rd) begin
      state_next.rsp_valid = 1'b1;
      unique case (base)
        hdic_pkg::CMD_HW[6:0]: state_next.rsp_data = state_reg.hw;
        hdic_pkg::CMD_DMA[6:0]: state_next.rsp_data = state_reg.dma;
        hdic_pkg::CMD_CNT[6:0]: state_next.rsp_data = state_reg.cnt;
        hdic_pkg::CMD_EVT[6:0]: state_next.rsp_data = state_reg.evt;
        hdic_pkg::CMD_MASK[6:0]: state_next.rsp_data = state_reg.mask;
        default: state_next.rsp_data = '0;
      endcase
    end

    // Transfer sequencing; DONE waits for software to drop the enable.
    unique case (state_reg.st)
      hdic_pkg::DMA_IDLE: begin
        // A count only arms the request once the counter is enabled.
        if (state_reg.dma[hdic_pkg::DMA_XFER_EN] &&
            state_reg.dma[hdic_pkg::DMA_CNT_EN] &&
            state_reg.cnt != '0) begin
          state_next.st = hdic_pkg::DMA_ACTIVE;
        end
      end
      hdic_pkg::DMA_ACTIVE: begin
        if (!state_reg.dma[hdic_pkg::DMA_XFER_EN] ||
            !state_reg.dma[hdic_pkg::DMA_CNT_EN]) begin
          state_next.st = hdic_pkg::DMA_IDLE;
        end else if (done_now) begin
          state_next.st = hdic_pkg::DMA_DONE;
        end
      end
      hdic_pkg::DMA_DONE: begin
        // Software must clear the enable before a new transfer.
        if (!state_reg.dma[hdic_pkg::DMA_XFER_EN]) begin
          state_next.st = hdic_pkg::DMA_IDLE;
        end
      end
    endcase

    // Host interrupt needs the global pin enable and an unmasked flag.
    raw_irq = state_reg.hw[hdic_pkg::HW_IRQ_EN] &&
      (|(state_reg.evt & state_reg.mask));
    state_next.raw_d = raw_irq;
    // Edge mode gives a one-cycle pulse on each rise of the request.
    host_irq = state_reg.hw[hdic_pkg::HW_IRQ_TRIG] ?
      (raw_irq && !state_reg.raw_d) : raw_irq;

    // Interrupt routing; pin two rests inactive when merged.
    if (state_reg.hw[hdic_pkg::HW_ONE_IRQ]) begin
      one_act = host_irq || periph_irq_i;
      two_act = 1'b0;
    end else begin
      one_act = host_irq;
      two_act = periph_irq_i;
    end
    state_next.irq_one = hdic_pkg::pol_apply(one_act,
      state_reg.hw[hdic_pkg::HW_IRQ_POL]);
    state_next.irq_two = hdic_pkg::pol_apply(two_act,
      state_reg.hw[hdic_pkg::HW_IRQ_POL]);

    // Request pin one follows the next state so it drops with it; pin two follows the peripheral only when split.
    req1_act = (state_next.st == hdic_pkg::DMA_ACTIVE) ||
      (state_reg.hw[hdic_pkg::HW_ONE_XFER] && periph_req_i);
    state_next.req_one = hdic_pkg::pol_apply(req1_act,
      state_reg.hw[hdic_pkg::HW_REQ_POL]);
    state_next.req_two = !state_reg.hw[hdic_pkg::HW_ONE_XFER] &&
      periph_req_i;

    // Overcurrent source selection.
    state_next.oc = state_reg.hw[hdic_pkg::HW_OC_SEL] ?
      oc_analog_i : oc_digital_i;
  end

  // One register for the whole state; reset is synchronous.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= hdic_pkg::DEV_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Every output is a field of the state register.
  assign bus.rsp_valid = state_reg.rsp_valid;
  assign bus.rsp_data = state_reg.rsp_data;
  assign bus.irq_one = state_reg.irq_one;
  assign bus.irq_two = state_reg.irq_two;
  assign bus.req_one = state_reg.req_one;
  assign bus.req_two = state_reg.req_two;
  assign periph_ack_o = state_reg.periph_ack;
  assign overcurrent_o = state_reg.oc;
  assign eot_o = state_reg.end_of_transfer;
  assign buf_state_upd_o = state_reg.buf_upd;
  assign word_done_o = state_reg.word;
  // Direction 0 means the transfer reads the host buffer memory.
  assign xfer_dir_o = state_reg.dma[hdic_pkg::DMA_DIR];
  assign burst_len_o = state_reg.dma[hdic_pkg::DMA_BURST_LO +: 2];
  assign buf_sel_o = state_reg.dma[hdic_pkg::DMA_BUF_LO +: 3];

endmodule : hdic_device

//--- core/hdic_host.sv
// Controller end: turns software register writes into link commands,
// collects read answers and acknowledges transfer requests.
// Assumes software keeps the device settings legal and the device
// answers each read in the cycle after the command.
`timescale 1ns/100ps
module hdic_host (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Software register port.
  input wire logic [hdic_pkg::HADDR_W-1:0] addr_i,
  input wire logic [15:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [15:0] rd_data_o,
  // Link to the device.
  hdic_bus_if.host bus
);

  // Registered state and its next value.
  hdic_pkg::hdic_host_t state_reg;
  hdic_pkg::hdic_host_t state_next;
  logic req1_act; // Request one at its active level.
  logic [3:0] stat; // Live status word.

  // Command issue, answer capture and acknowledge pacing.
  always_comb begin
    state_next = state_reg;
    state_next.cmd_valid = 1'b0;
    state_next.rd_data = '0;
    req1_act = hdic_pkg::pol_apply(bus.req_one,
      state_reg.ctrl[hdic_pkg::CTRL_REQ_POL]);
    stat = {req1_act,
      hdic_pkg::pol_apply(bus.irq_two, state_reg.ctrl[hdic_pkg::CTRL_IRQ_POL]),
      hdic_pkg::pol_apply(bus.irq_one, state_reg.ctrl[hdic_pkg::CTRL_IRQ_POL]),
      state_reg.rx_new};

    // Writes; a command write launches the code with the held data.
    if (wr_i) begin
      unique case (addr_i)
        hdic_pkg::H_DATA: state_next.data = wr_data_i;
        hdic_pkg::H_CMD: begin
          // Software supplies legal codes and settings for the device.
          state_next.cmd_valid = 1'b1;
          state_next.cmd_code = wr_data_i[7:0];
          state_next.cmd_wdata = state_reg.data;
        end
        hdic_pkg::H_CTRL: state_next.ctrl = wr_data_i[3:0];
        default: state_next.ctrl = state_reg.ctrl;
      endcase
    end

    // Reads answer in the next cycle only; reading RX drops its flag.
    if (rd_i) begin
      unique case (addr_i)
        hdic_pkg::H_DATA: state_next.rd_data = state_reg.data;
        hdic_pkg::H_RX: begin
          state_next.rd_data = state_reg.rx;
          state_next.rx_new = 1'b0;
        end
        hdic_pkg::H_STAT: state_next.rd_data = {12'h000, stat};
        hdic_pkg::H_CTRL: state_next.rd_data = {12'h000, state_reg.ctrl};
        default: state_next.rd_data = '0;
      endcase
    end

    // A fresh answer sets the flag even against a same-cycle read.
    if (bus.rsp_valid) begin
      state_next.rx = bus.rsp_data;
      state_next.rx_new = 1'b1;
    end

    // One-cycle acknowledge, then a gap, so the device can drop request
    // before a surplus word is taken.
    state_next.ack1_act = state_reg.ctrl[hdic_pkg::CTRL_ACK_EN] &&
      req1_act && !state_reg.ack1_act;
    state_next.ack_one = hdic_pkg::pol_apply(state_next.ack1_act,
      state_reg.ctrl[hdic_pkg::CTRL_ACK_POL]);
    state_next.ack_two = state_reg.ctrl[hdic_pkg::CTRL_ACK_EN] &&
      bus.req_two && !state_reg.ack_two;
  end

  // One register for the whole state; reset is synchronous.
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      state_reg <= hdic_pkg::HOST_RESET;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs are fields of the state register.
  assign rd_data_o = state_reg.rd_data;
  assign bus.cmd_valid = state_reg.cmd_valid;
  assign bus.cmd_code = state_reg.cmd_code;
  assign bus.cmd_wdata = state_reg.cmd_wdata;
  assign bus.ack_one = state_reg.ack_one;
  assign bus.ack_two = state_reg.ack_two;

endmodule : hdic_host

//--- verification/hdic_asserts.sv
// Link checker for the host transfer and interrupt pin setup block.
// Assumes the link signals arrive as plain inputs on one clock.
`timescale 1ns/100ps
module hdic_asserts (
  // Clock and reset.
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // Controller to device.
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_wdata,
  // Device to controller.
  input wire logic rsp_valid,
  input wire logic [15:0] rsp_data,
  input wire logic irq_one,
  input wire logic irq_two,
  input wire logic req_one,
  input wire logic req_two
);
  // Merge and polarity bits copied from pin setup writes, so pin checks
  // follow what software set rather than the reset defaults.
  logic [3:0] cfg_reg;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      cfg_reg <= 4'h1;
    end else if (cmd_valid && cmd_code == 8'hA0) begin
      cfg_reg <= {cmd_wdata[7], cmd_wdata[9], cmd_wdata[2], cmd_wdata[5]};
    end
  end
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Read command, count read after a count load, and transfer arming.
  sequence s_rd;
    cmd_valid && !cmd_code[7];
  endsequence
  sequence s_cnt_rd;
    cmd_valid && cmd_code == 8'h22 && $past(cmd_valid && cmd_code == 8'hA2, 2);
  endsequence
  sequence s_arm;
    cmd_valid && cmd_code == 8'hA1 && cmd_wdata[7] && cmd_wdata[4] &&
      $past(cmd_valid && cmd_code == 8'hA2 && cmd_wdata != 16'h0000, 4);
  endsequence
  property p_rsp_fwd;
    s_rd |=> rsp_valid;
  endproperty
  a_rsp_fwd: assert property (p_rsp_fwd)
    else $error("read command not answered");
  property p_rsp_back;
    rsp_valid |-> $past(cmd_valid && !cmd_code[7]);
  endproperty
  a_rsp_back: assert property (p_rsp_back)
    else $error("answer without read command");
  property p_rsp_zero;
    !rsp_valid |-> rsp_data == 16'h0000;
  endproperty
  a_rsp_zero: assert property (p_rsp_zero)
    else $error("answer data outside answer");
  property p_dma_hi;
    cmd_valid && cmd_code == 8'h21 |=> rsp_data[15:8] == 8'h00;
  endproperty
  a_dma_hi: assert property (p_dma_hi)
    else $error("transfer setup upper byte set");
  property p_width;
    cmd_valid && cmd_code == 8'h20 |=> rsp_data[4:3] == 2'b01;
  endproperty
  a_width: assert property (p_width)
    else $error("bus width not 16 bit code");
  property p_cnt_rw;
    s_cnt_rd |=> rsp_data == $past(cmd_wdata, 3);
  endproperty
  a_cnt_rw: assert property (p_cnt_rw)
    else $error("byte count read differs");
  property p_req_off;
    cmd_valid && cmd_code == 8'hA1 && !cmd_wdata[4] |=> ##1
      req_one != cfg_reg[0];
  endproperty
  a_req_off: assert property (p_req_off)
    else $error("request stays after disable");
  property p_req_arm;
    s_arm |=> ##1 req_one == cfg_reg[0];
  endproperty
  a_req_arm: assert property (p_req_arm)
    else $error("request not raised after arming");
  property p_irq2_idle;
    cfg_reg[2] && $past(cfg_reg[2]) && $stable(cfg_reg[1]) |->
      irq_two == !cfg_reg[1];
  endproperty
  a_irq2_idle: assert property (p_irq2_idle)
    else $error("second interrupt pin used when merged");
  property p_req2_idle;
    cfg_reg[3] && $past(cfg_reg[3]) |-> !req_two;
  endproperty
  a_req2_idle: assert property (p_req2_idle)
    else $error("second request pin used when merged");
endmodule : hdic_asserts

//--- verification/test_host_dma_irq_config.sv
// Testbench joining the controller end and the device end over the link.
// Assumes one 50 MHz clock and the software port of the controller.
`timescale 1ns/100ps
module test_host_dma_irq_config;
  // Clock, reset and software port.
  logic sys_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  logic [15:0] wr_data_i = 16'h0000;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [15:0] rd_data_o;
  // Device side pins.
  logic [9:0] host_evt_i = 10'h000;
  logic periph_irq_i = 1'b0;
  logic periph_req_i = 1'b0;
  logic oc_digital_i = 1'b0;
  logic oc_analog_i = 1'b0;
  logic periph_ack_o;
  logic overcurrent_o;
  logic eot_o;
  logic buf_state_upd_o;
  logic word_done_o;
  logic xfer_dir_o;
  logic [1:0] burst_len_o;
  logic [2:0] buf_sel_o;
  // Scores and model state.
  int errors = 0;
  int tests_run = 0;
  int m_dma = 0;
  int n;
  int k;
  logic [15:0] v;
  logic [15:0] w;
  hdic_bus_if bus_if_i ();
  hdic_host hdic_host_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .bus(bus_if_i.host));
  hdic_device hdic_device_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .bus(bus_if_i.dev), .host_evt_i(host_evt_i),
    .periph_irq_i(periph_irq_i), .periph_req_i(periph_req_i),
    .periph_ack_o(periph_ack_o), .oc_digital_i(oc_digital_i),
    .oc_analog_i(oc_analog_i), .overcurrent_o(overcurrent_o),
    .eot_o(eot_o), .buf_state_upd_o(buf_state_upd_o),
    .word_done_o(word_done_o), .xfer_dir_o(xfer_dir_o),
    .burst_len_o(burst_len_o), .buf_sel_o(buf_sel_o));
  hdic_asserts hdic_asserts_i (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .cmd_valid(bus_if_i.cmd_valid), .cmd_code(bus_if_i.cmd_code),
    .cmd_wdata(bus_if_i.cmd_wdata), .rsp_valid(bus_if_i.rsp_valid),
    .rsp_data(bus_if_i.rsp_data), .irq_one(bus_if_i.irq_one),
    .irq_two(bus_if_i.irq_two), .req_one(bus_if_i.req_one),
    .req_two(bus_if_i.req_two));
  // Free running clock.
  always #10 sys_clk_i = ~sys_clk_i;
  // One software write; a clock edge passes before the next strobe.
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    wr_data_i <= d;
    wr_i <= 1'b1;
    @(posedge sys_clk_i);
    wr_i <= 1'b0;
  endtask : wr
  // One software read; the data stand only in the following cycle.
  task automatic rd(input logic [4:0] a, output logic [15:0] d);
    @(posedge sys_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge sys_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask : rd
  // Link write: data first, then the command launches it.
  task automatic lw(input logic [7:0] c, input logic [15:0] d);
    wr(hdic_pkg::H_DATA, d);
    wr(hdic_pkg::H_CMD, {8'h00, c});
  endtask : lw
  // Link read: the answer lands in the receive register two cycles later.
  task automatic lr(input logic [7:0] c, output logic [15:0] d);
    wr(hdic_pkg::H_CMD, {8'h00, c});
    @(posedge sys_clk_i);
    rd(hdic_pkg::H_RX, d);
  endtask : lr
  task automatic cmpw(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : cmpw
  task automatic cmpp(input string nm, input logic e, input logic g);
    tests_run++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %b seen %b", nm, e, g);
    end
  endtask : cmpp
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : test_done
  // Main sequence.
  initial begin
    n = $urandom(4);
    repeat (20) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    lr(8'h20, v);
    cmpw("pin setup", 16'h0028, v);
    lr(8'h21, v);
    cmpw("transfer setup", 16'h0000, v);
    lr(8'h22, v);
    cmpw("byte count", 16'h0000, v);
    $display("test reset done");
    // Every burst code; the reserved one must leave the old burst.
    for (int b = 0; b < 4; b++) begin
      v = (16'($urandom) & 16'hFF0F) | 16'(b << 5);
      m_dma = (b == 3) ? ((m_dma & 16'h0060) | (v & 16'h009F)) : (v & 16'h00FF);
      lw(8'hA1, v);
      lr(8'h21, v);
      cmpw("transfer setup", 16'(m_dma), v);
      cmpw("setup pins", 16'(m_dma & 16'h006F),
        {9'h000, burst_len_o, 1'b0, buf_sel_o, xfer_dir_o});
      v = 16'($urandom);
      lw(8'hA2, v);
      lr(8'h22, w);
      cmpw("byte count", v, w);
    end
    $display("test fields done");
    // Split and merged routing, overcurrent source, reserved width.
    periph_irq_i <= 1'b1;
    periph_req_i <= 1'b1;
    for (int m = 0; m < 2; m++) begin
      oc_digital_i <= 1'($urandom);
      oc_analog_i <= 1'($urandom);
      lw(8'hA0, 16'h0030 | 16'(m * 16'h0680));
      lr(8'h20, v);
      cmpw("pin setup", 16'h0028 | 16'(m * 16'h0680), v);
      cmpp("irq one", 1'(1 - m), bus_if_i.irq_one);
      cmpp("irq two", 1'(m), bus_if_i.irq_two);
      cmpp("req one", 1'(m), bus_if_i.req_one);
      cmpp("req two", 1'(1 - m), bus_if_i.req_two);
      cmpp("overcurrent", m ? oc_analog_i : oc_digital_i,
        overcurrent_o);
    end
    periph_irq_i <= 1'b0;
    periph_req_i <= 1'b0;
    $display("test routing done");
    // Level then edge interrupt from one masked event source.
    k = $urandom % 10;
    lw(8'hA5, 16'(1 << k));
    for (int t = 0; t < 2; t++) begin
      lw(8'hA0, 16'h0029 | 16'(t << 1));
      @(posedge sys_clk_i);
      host_evt_i <= 10'(1 << k);
      @(posedge sys_clk_i);
      host_evt_i <= 10'h000;
      repeat (3) @(posedge sys_clk_i);
      #1;
      cmpp("irq one", 1'(t), bus_if_i.irq_one);
      lw(8'hA4, 16'(1 << k));
      lr(8'h24, v);
      cmpw("events", 16'h0000, v);
      cmpp("irq one", 1'b1, bus_if_i.irq_one);
    end
    $display("test interrupt done");
    // Full transfers with low, then high, acknowledge and request pins.
    for (int p = 0; p < 2; p++) begin
      lw(8'hA0, 16'h0009 | 16'(p * 16'h0060));
      wr(hdic_pkg::H_CTRL, 16'(1 + 6 * p));
      n = 1 + $urandom % 40;
      lw(8'hA2, 16'(n));
      lw(8'hA1, 16'h0090);
      k = 0;
      for (int i = 0; i < 300 && eot_o !== 1'b1; i++) begin
        @(posedge sys_clk_i);
        #1;
        if (word_done_o === 1'b1) k++;
      end
      cmpp("end of transfer", 1'b1, eot_o);
      cmpp("buffer update", 1'b1, buf_state_upd_o);
      cmpw("acks", 16'((n + 1) / 2), 16'(k));
      cmpp("req one", 1'(1 - p), bus_if_i.req_one);
      lr(8'h24, v);
      cmpw("events", 16'h0004, v);
      lr(8'h22, v);
      cmpw("byte count", 16'h0000, v);
      lw(8'hA4, 16'h0004);
      lw(8'hA1, 16'h0080);
      $display("test transfer done");
    end
    // No request with a zero count, nor without the counter enable.
    for (int j = 0; j < 2; j++) begin
      lw(8'hA2, 16'(16 * j));
      lw(8'hA1, j ? 16'h0010 : 16'h0090);
      repeat (4) @(posedge sys_clk_i);
      #1;
      cmpp("req one", 1'b0, bus_if_i.req_one);
      lw(8'hA1, 16'h0000);
    end
    $display("test unarmed done");
    test_done();
  end
  // Watchdog well beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge sys_clk_i);
    errors++;
    $display("MISMATCH watchdog expected finish seen timeout");
    test_done();
  end
endmodule : test_host_dma_irq_config
